// ===== verilog/sdp_divider_regs.sv
// Purpose: write-only power-down and divider register bank of a dual-band synthesizer
// Assumes: one whole 18-bit word arrives per word_valid_i pulse, already deserialised
// Notes: writes to any other address are ignored; no register reads back
//
// Overview of operation
// - a word at address 0010 is stored in the power-down register.
// - power-down bit 1 turns the IF synthesizer off at 0, on at 1.
// - power-down bit 0 turns the RF synthesizer off at 0, on at 1.
// - address 0011 loads all 18 data bits as first RF feedback count.
// - address 0100 loads bits 16..0 as second RF feedback count; host zeroes bit 17.
// - address 0101 loads bits 15..0 as IF feedback count; host zeroes bits 17..16.
// - address 0110 loads 13-bit first RF reference count, host keeps min..8189.
// - address 0111 loads 13-bit second RF reference count, host keeps min..8189.
// - address 1000 loads 13-bit IF reference count, minimum set by first gain code.
// - auto power-down high forces both synthesizers on; low lets the register govern.
`default_nettype none

module sdp_divider_regs (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic word_valid_i,
	input wire logic [3:0] word_addr_i,
	input wire logic [17:0] word_data_i,
	input wire logic auto_power_down_i,
	input wire logic [1:0] first_loop_gain_code_i,
	input wire logic [1:0] second_loop_gain_code_i,
	output logic if_synth_on_o,
	output logic rf_synth_on_o,
	output logic [17:0] rf1_feedback_count_o,
	output logic [16:0] rf2_feedback_count_o,
	output logic [15:0] if_feedback_count_o,
	output logic [12:0] rf1_reference_count_o,
	output logic [12:0] rf2_reference_count_o,
	output logic [12:0] if_reference_count_o,
	output logic rf1_ref_ok_o,
	output logic rf2_ref_ok_o,
	output logic if_ref_ok_o
);

	// address decode
	wire logic wr_pd_w;
	wire logic wr_rf1_n_w;
	wire logic wr_rf2_n_w;
	wire logic wr_if_n_w;
	wire logic [sdp_pkg::NUM_REF-1:0] wr_ref_w;

	assign wr_pd_w = word_valid_i && (word_addr_i == sdp_pkg::ADDR_POWER_DOWN);
	assign wr_rf1_n_w = word_valid_i && (word_addr_i == sdp_pkg::ADDR_RF1_FEEDBACK);
	assign wr_rf2_n_w = word_valid_i && (word_addr_i == sdp_pkg::ADDR_RF2_FEEDBACK);
	assign wr_if_n_w = word_valid_i && (word_addr_i == sdp_pkg::ADDR_IF_FEEDBACK);
	assign wr_ref_w[0] = word_valid_i && (word_addr_i == sdp_pkg::ADDR_RF1_REFERENCE);
	assign wr_ref_w[1] = word_valid_i && (word_addr_i == sdp_pkg::ADDR_RF2_REFERENCE);
	assign wr_ref_w[2] = word_valid_i && (word_addr_i == sdp_pkg::ADDR_IF_REFERENCE);

	// power-down register and effective synthesizer enables
	logic [1:0] pd_q;
	logic [1:0] pd_d;
	logic [1:0] on_q;
	logic [1:0] on_d;

	// reserved bits 17..2 are dropped rather than stored
	assign pd_d = wr_pd_w ? word_data_i[1:0] : pd_q;
	// auto power-down overrides both enables without touching the stored bits
	assign on_d = pd_d | {2{auto_power_down_i}};

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pd_q <= sdp_pkg::POWER_DOWN_RST;
			on_q <= sdp_pkg::POWER_DOWN_RST;
		end else begin
			pd_q <= pd_d;
			on_q <= on_d;
		end
	end

	assign if_synth_on_o = on_q[sdp_pkg::IF_ON_BIT];
	assign rf_synth_on_o = on_q[sdp_pkg::RF_ON_BIT];

	// feedback divide counts
	logic [17:0] rf1_n_q;
	logic [16:0] rf2_n_q;
	logic [15:0] if_n_q;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rf1_n_q <= sdp_pkg::RF1_N_RST;
			rf2_n_q <= sdp_pkg::RF2_N_RST;
			if_n_q <= sdp_pkg::IF_N_RST;
		end else begin
			if (wr_rf1_n_w) begin
				rf1_n_q <= word_data_i[sdp_pkg::RF1_N_W-1:0];
			end
			if (wr_rf2_n_w) begin
				rf2_n_q <= word_data_i[sdp_pkg::RF2_N_W-1:0];
			end
			if (wr_if_n_w) begin
				if_n_q <= word_data_i[sdp_pkg::IF_N_W-1:0];
			end
		end
	end

	assign rf1_feedback_count_o = rf1_n_q;
	assign rf2_feedback_count_o = rf2_n_q;
	assign if_feedback_count_o = if_n_q;

	// reference divide counts with range status; IF shares the first loop gain code
	wire logic [1:0] gain_w [sdp_pkg::NUM_REF];
	logic [sdp_pkg::REF_W-1:0] ref_q [sdp_pkg::NUM_REF];
	logic [sdp_pkg::NUM_REF-1:0] ok_q;

	assign gain_w[0] = first_loop_gain_code_i;
	assign gain_w[1] = second_loop_gain_code_i;
	assign gain_w[2] = first_loop_gain_code_i;

	for (genvar i = 0; i < sdp_pkg::NUM_REF; i++) begin : g_ref
		wire logic [sdp_pkg::REF_W-1:0] ref_d_w;
		wire logic ok_w;

		assign ref_d_w = wr_ref_w[i] ? word_data_i[sdp_pkg::REF_W-1:0] : ref_q[i];

		// the host owns the legal window; the device only reports a violation
		sdp_ref_range #(
			.CNT_W(sdp_pkg::REF_W)
		) u_range (
			.count_i(ref_d_w),
			.gain_code_i(gain_w[i]),
			.in_range_o(ok_w)
		);

		always_ff @(posedge ref_clk_i or posedge reset_i) begin
			if (reset_i) begin
				ref_q[i] <= sdp_pkg::REF_RST;
				ok_q[i] <= 1'b0;
			end else begin
				ref_q[i] <= ref_d_w;
				ok_q[i] <= ok_w;
			end
		end
	end

	assign rf1_reference_count_o = ref_q[0];
	assign rf2_reference_count_o = ref_q[1];
	assign if_reference_count_o = ref_q[2];
	assign rf1_ref_ok_o = ok_q[0];
	assign rf2_ref_ok_o = ok_q[1];
	assign if_ref_ok_o = ok_q[2];

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	pd_write_load_a: assert property (wr_pd_w |=> (pd_q == $past(word_data_i[1:0])))
		else $error("power-down register did not take the written bits");

	// stored bits only move on a write to their own address
	pd_hold_a: assert property ((!wr_pd_w ##1 !wr_pd_w)
		|-> $stable(pd_q))
		else $error("power-down register changed without a write");

	if_on_follow_a: assert property ((wr_pd_w && !auto_power_down_i)
		|=> (if_synth_on_o == $past(word_data_i[1])))
		else $error("IF enable does not follow written bit 1");

	rf_on_follow_a: assert property ((wr_pd_w && !auto_power_down_i)
		|=> (rf_synth_on_o == $past(word_data_i[0])))
		else $error("RF enable does not follow written bit 0");

	rf1_n_load_a: assert property (wr_rf1_n_w |=> (rf1_feedback_count_o == $past(word_data_i)))
		else $error("first RF feedback count not loaded");

	rf1_n_hold_a: assert property ((!wr_rf1_n_w ##1 !wr_rf1_n_w)
		|-> $stable(rf1_feedback_count_o))
		else $error("first RF feedback count changed without a write");

	rf2_n_load_a: assert property (wr_rf2_n_w
		|=> (rf2_feedback_count_o == $past(word_data_i[16:0])))
		else $error("second RF feedback count not loaded");

	rf2_n_hold_a: assert property ((!wr_rf2_n_w ##1 !wr_rf2_n_w)
		|-> $stable(rf2_feedback_count_o))
		else $error("second RF feedback count changed without a write");

	if_n_hold_a: assert property ((!wr_if_n_w ##1 !wr_if_n_w) |-> $stable(if_feedback_count_o))
		else $error("IF feedback count changed without a write");

	if_n_load_a: assert property (wr_if_n_w |=> (if_feedback_count_o == $past(word_data_i[15:0])))
		else $error("IF feedback count not loaded");

	rf1_ref_load_a: assert property (wr_ref_w[0]
		|=> (rf1_reference_count_o == $past(word_data_i[12:0])))
		else $error("first RF reference count not loaded");

	rf1_ref_min_a: assert property ((wr_ref_w[0] && (word_data_i[12:0] == 13'h0007)
		&& (first_loop_gain_code_i == 2'h0)) |=> rf1_ref_ok_o)
		else $error("first RF reference at its minimum reported as illegal");

	rf2_ref_load_a: assert property (wr_ref_w[1]
		|=> (rf2_reference_count_o == $past(word_data_i[12:0])))
		else $error("second RF reference count not loaded");

	rf2_ref_max_a: assert property ((wr_ref_w[1] && (word_data_i[12:0] == 13'h1ffd))
		|=> rf2_ref_ok_o)
		else $error("second RF reference at the ceiling reported as illegal");

	rf2_ref_range_a: assert property ((wr_ref_w[1] && (word_data_i[12:0] == 13'h000d)
		&& (second_loop_gain_code_i == 2'h3)) |=> !rf2_ref_ok_o)
		else $error("second RF reference below minimum reported as legal");

	if_ref_load_a: assert property (wr_ref_w[2]
		|=> (if_reference_count_o == $past(word_data_i[12:0])))
		else $error("IF reference count not loaded");

	if_ref_gain_a: assert property ((wr_ref_w[2] && (word_data_i[12:0] == 13'h000a)
		&& (first_loop_gain_code_i == 2'h2)) |=> if_ref_ok_o)
		else $error("IF reference minimum not taken from the first gain code");

	if_ref_range_a: assert property ((wr_ref_w[2] && (word_data_i[12:0] == 13'h1ffe))
		|=> !if_ref_ok_o)
		else $error("IF reference above ceiling reported as legal");

	auto_force_on_a: assert property (auto_power_down_i
		|=> (if_synth_on_o && rf_synth_on_o)[*2] or $fell(auto_power_down_i))
		else $error("auto power-down did not force both synthesizers on");

endmodule : sdp_divider_regs

`default_nettype wire

// ===== verilog/sdp_pkg.sv
// Purpose: constants shared by the synthesizer divider and power-down register bank
// Assumes: 18-bit data words selected by a 4-bit address field
// Notes: all reset values are zero, so both synthesizers start powered down
`default_nettype none

package sdp_pkg;

	localparam int unsigned WORD_W = 18;
	localparam int unsigned ADDR_W = 4;

	localparam logic [3:0] ADDR_POWER_DOWN = 4'h2;
	localparam logic [3:0] ADDR_RF1_FEEDBACK = 4'h3;
	localparam logic [3:0] ADDR_RF2_FEEDBACK = 4'h4;
	localparam logic [3:0] ADDR_IF_FEEDBACK = 4'h5;
	localparam logic [3:0] ADDR_RF1_REFERENCE = 4'h6;
	localparam logic [3:0] ADDR_RF2_REFERENCE = 4'h7;
	localparam logic [3:0] ADDR_IF_REFERENCE = 4'h8;

	localparam int unsigned RF_ON_BIT = 0;
	localparam int unsigned IF_ON_BIT = 1;

	localparam int unsigned RF1_N_W = 18;
	localparam int unsigned RF2_N_W = 17;
	localparam int unsigned IF_N_W = 16;
	localparam int unsigned REF_W = 13;
	localparam int unsigned NUM_REF = 3;

	localparam logic [1:0] POWER_DOWN_RST = 2'h0;
	localparam logic [17:0] RF1_N_RST = 18'h0_0000;
	localparam logic [16:0] RF2_N_RST = 17'h0_0000;
	localparam logic [15:0] IF_N_RST = 16'h0000;
	localparam logic [12:0] REF_RST = 13'h0000;

	// least legal reference count for gain codes 0..3, and the common ceiling
	localparam logic [12:0] REF_MIN_GC0 = 13'h0007;
	localparam logic [12:0] REF_MIN_GC1 = 13'h0008;
	localparam logic [12:0] REF_MIN_GC2 = 13'h000a;
	localparam logic [12:0] REF_MIN_GC3 = 13'h000e;
	localparam logic [12:0] REF_MAX = 13'h1ffd;

endpackage : sdp_pkg

`default_nettype wire

// ===== verilog/sdp_ref_range.sv
// Purpose: checks a reference divide count against the window set by a gain code
// Assumes: count and gain code are stable for the cycle
// Notes: purely combinational; the caller registers the verdict
`default_nettype none

module sdp_ref_range #(
	parameter int unsigned CNT_W = 13
) (
	input wire logic [CNT_W-1:0] count_i,
	input wire logic [1:0] gain_code_i,
	output logic in_range_o
);

	if (CNT_W != sdp_pkg::REF_W) begin : g_bad_width
		$error("sdp_ref_range: CNT_W must equal the reference count width");
	end

	wire logic [CNT_W-1:0] min_w;

	assign min_w = (gain_code_i == 2'h0) ? sdp_pkg::REF_MIN_GC0 :
		(gain_code_i == 2'h1) ? sdp_pkg::REF_MIN_GC1 :
		(gain_code_i == 2'h2) ? sdp_pkg::REF_MIN_GC2 : sdp_pkg::REF_MIN_GC3;
	assign in_range_o = (count_i >= min_w) && (count_i <= sdp_pkg::REF_MAX);

endmodule : sdp_ref_range

`default_nettype wire

// ===== bench/sdp_host_model.sv
// Purpose: host side that hands whole configuration words to the register bank
// Assumes: deserialised words, one-cycle valid pulse, driven at the falling edge
// Notes: stale lines are inverted after each word so a late capture shows up
`default_nettype none

module sdp_host_model (
	input wire logic ref_clk_i,
	output var logic word_valid_o,
	output var logic [3:0] word_addr_o,
	output var logic [17:0] word_data_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		word_valid_o = 1'b0;
		word_addr_o = 4'h0;
		word_data_o = 18'h0_0000;
	end

	// complete word each time, reserved bits cleared
	task automatic send(input logic [3:0] addr, input logic [17:0] value);
		logic [17:0] keep;
		keep = (addr == 4'h2) ? 18'h0_0003 : (addr == 4'h4) ? 18'h1_ffff :
			(addr == 4'h5) ? 18'h0_ffff : (addr >= 4'h6) ? 18'h0_1fff : 18'h3_ffff;
		@(negedge ref_clk_i);
		word_valid_o = 1'b1;
		word_addr_o = addr;
		word_data_o = value & keep;
		@(negedge ref_clk_i);
		word_valid_o = 1'b0;
		word_addr_o = ~word_addr_o;
		word_data_o = ~word_data_o;
	endtask : send
endmodule : sdp_host_model

`default_nettype wire

// ===== bench/sdp_bench.sv
// Purpose: self-checking bench for the divider and power-down register bank
// Assumes: results are looked at on the falling edge after the capturing edge
// Notes: reference counts stay inside the legal window unless the ok flag is probed
`default_nettype none

module synth_divider_powerdown_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic auto = 1'b0;
	logic [1:0] gc1 = 2'h0;
	logic [1:0] gc2 = 2'h0;
	logic valid, if_on, rf_on, ok1, ok2, oki;
	logic [3:0] addr;
	logic [17:0] data, n1;
	logic [16:0] n2;
	logic [15:0] ni;
	logic [12:0] r1, r2, ri;
	int err_total = 0;
	int samples_checked = 0;

	always #20 ref_clk_i = ~ref_clk_i;

	sdp_host_model u_sdp_host_model (.ref_clk_i(ref_clk_i), .word_valid_o(valid), .word_addr_o(addr),
		.word_data_o(data));

	sdp_divider_regs u_sdp_divider_regs (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .word_valid_i(valid),
		.word_addr_i(addr), .word_data_i(data), .auto_power_down_i(auto), .first_loop_gain_code_i(gc1),
		.second_loop_gain_code_i(gc2), .if_synth_on_o(if_on), .rf_synth_on_o(rf_on),
		.rf1_feedback_count_o(n1), .rf2_feedback_count_o(n2), .if_feedback_count_o(ni),
		.rf1_reference_count_o(r1), .rf2_reference_count_o(r2), .if_reference_count_o(ri),
		.rf1_ref_ok_o(ok1), .rf2_ref_ok_o(ok2), .if_ref_ok_o(oki));

	task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic power_test;
		check(18'({if_on, rf_on, ok1, ok2, oki}), 18'h0_0000, "flags after reset");
		check(n1, 18'h0_0000, "rf1 feedback after reset");
		check(18'(r1 | r2 | ri), 18'h0_0000, "references after reset");
		u_sdp_host_model.send(4'h2, 18'h0_0002);
		check(18'({if_on, rf_on}), 18'h0_0002, "if on only");
		u_sdp_host_model.send(4'h2, 18'h0_0001);
		check(18'({if_on, rf_on}), 18'h0_0001, "rf on only");
		auto = 1'b1;
		@(negedge ref_clk_i);
		check(18'({if_on, rf_on}), 18'h0_0003, "auto forces on");
		auto = 1'b0;
		@(negedge ref_clk_i);
		check(18'({if_on, rf_on}), 18'h0_0001, "stored bits back");
	endtask : power_test

	task automatic feedback_test;
		u_sdp_host_model.send(4'h3, 18'h3_ffff);
		check(n1, 18'h3_ffff, "rf1 feedback");
		u_sdp_host_model.send(4'h4, 18'h1_a5a5);
		check(18'(n2), 18'h1_a5a5, "rf2 feedback");
		u_sdp_host_model.send(4'h5, 18'h0_5a5a);
		check(18'(ni), 18'h0_5a5a, "if feedback");
		check(n1, 18'h3_ffff, "rf1 kept");
	endtask : feedback_test

	// legal minimum probed for gain codes 0, 2 and 3, and the ceiling with gain code 3
	task automatic reference_test;
		u_sdp_host_model.send(4'h6, 18'h0_0007);
		check(18'({r1, ok1}), 18'h0_000f, "rf1 ref at min");
		gc1 = 2'h1;
		@(negedge ref_clk_i);
		check(18'(ok1), 18'h0_0000, "rf1 below min");
		gc2 = 2'h3;
		u_sdp_host_model.send(4'h7, 18'h0_1ffd);
		check(18'({r2, ok2}), 18'h0_3ffb, "rf2 ref at max");
		u_sdp_host_model.send(4'h7, 18'h0_000e);
		check(18'({r2, ok2}), 18'h0_001d, "rf2 ref at min");
		u_sdp_host_model.send(4'h7, 18'h0_000d);
		check(18'({r2, ok2}), 18'h0_001a, "rf2 ref below min");
		gc1 = 2'h2;
		u_sdp_host_model.send(4'h8, 18'h0_000a);
		check(18'({ri, oki}), 18'h0_0015, "if ref at min");
		gc1 = 2'h3;
		@(negedge ref_clk_i);
		check(18'(oki), 18'h0_0000, "if ref below min");
		u_sdp_host_model.send(4'h8, 18'h0_1ffe);
		check(18'({ri, oki}), 18'h0_3ffc, "if ref above max");
	endtask : reference_test

	task automatic unmapped_test;
		u_sdp_host_model.send(4'h9, 18'h0_1234);
		u_sdp_host_model.send(4'h1, 18'h0_0000);
		u_sdp_host_model.send(4'h0, 18'h0_0000);
		check(n1, 18'h3_ffff, "rf1 after unmapped");
		check(18'({ri, if_on, rf_on}), 18'h0_7ff9, "if ref and power kept");
	endtask : unmapped_test

	initial begin
		repeat (16) @(negedge ref_clk_i);
		reset_i = 1'b0;
		power_test();
		feedback_test();
		reference_test();
		unmapped_test();
		report_and_stop();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		err_total++;
		report_and_stop();
	end
endmodule : synth_divider_powerdown_regs_bench

`default_nettype wire
